//--- rtl/sfm_mapper.sv
// top of the servo function mapper: wishbone registers, config shadowing, alarm, interrupt
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - allocation words are 16 bits, four 4-bit digits, digit 1 lowest nibble.
// - optional input functions exist in words 4 and 5, unassigned by default.
// - default outputs: alarm 1, ready 2, zero speed 3, brake 4, in-position 5.
// - torque, velocity limiting, speed reached, warning outputs default unassigned.
// - two output functions on one contact raise the dual assignment alarm.
// - polarity bit 1 is normal contact, 0 is inverted contact.
// - low input polarity covers inputs 1 to 5, reset all normal.
// - high input polarity covers inputs 6 to 10, reset 0b10001.
// - output polarity resets to 0b10110: outputs 1 and 4 inverted.
// - config writes refused while servo is on; used only after reload.
// - first input word resets to 0x4321: servo enable and speed selects.
module sfm_mapper (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic servo_active,
    input wire logic cfg_reload,
    input wire logic [sfm_pkg::NUM_IN-1:0] input_contacts,
    input wire sfm_pkg::sfm_out_fn_s out_func,
    output sfm_pkg::sfm_in_fn_s in_func,
    output logic [sfm_pkg::NUM_OUT-1:0] output_contacts,
    output logic output_dual_assign_alarm,
    output logic irq
);
    import sfm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    sfm_state_s s_r;
    sfm_state_s s_nxt;

    logic [NUM_IN_FN-1:0] rt_in_fn;
    logic [NUM_OUT-1:0] rt_out_c;
    logic [NUM_OUT-1:0] rt_dual;

    logic req;
    logic wr;
    logic cfg_wr;
    logic refused;
    logic dual_any;
    logic pending;
    logic [5:0] widx;
    logic [2:0] in_k;
    logic [1:0] out_k;
    logic [31:0] rd;
    logic [ST_W-1:0] st_set;
    logic [ST_W-1:0] st_clr;

    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [15:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // routing always works from the active copy, never from what software
    // just wrote, so a half-written allocation can never glitch a contact
    sfm_route u_route (
        .cfg(s_r.active),
        .raw_in(input_contacts),
        .out_fn(out_func),
        .in_fn(rt_in_fn),
        .out_c(rt_out_c),
        .dual(rt_dual)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        req = wb_cyc_i & wb_stb_i & ~s_r.ack;
        wr = req & wb_we_i;
        widx = wb_adr_i[7:2];
        in_k = widx[2:0];
        out_k = 2'(widx - IDX_OUT_ALLOC);
        rd = 32'h0000_0000;
        cfg_wr = 1'b0;
        st_clr = '0;
        pending = (s_r.stored != s_r.active);
        dual_any = |rt_dual;

        s_nxt.ack = req;

        // register decode; reads return the stored (not yet active) values
        if (widx < IDX_OUT_ALLOC) begin
            rd = {16'h0000, s_r.stored.in_alloc[in_k]};
            cfg_wr = wr;
            if (wr && !servo_active) begin
                s_nxt.stored.in_alloc[in_k] =
                    merge16(s_r.stored.in_alloc[in_k], wb_dat_i, wb_sel_i);
            end
        end else if (widx < IDX_IN_POL_LO) begin
            rd = {16'h0000, s_r.stored.out_alloc[out_k]};
            cfg_wr = wr;
            if (wr && !servo_active) begin
                s_nxt.stored.out_alloc[out_k] =
                    merge16(s_r.stored.out_alloc[out_k], wb_dat_i, wb_sel_i);
            end
        end else begin
            case (widx)
                IDX_IN_POL_LO: begin
                    rd = {27'h0000000, s_r.stored.in_pol_lo};
                    cfg_wr = wr;
                    if (wr && !servo_active && wb_sel_i[0]) begin
                        s_nxt.stored.in_pol_lo = wb_dat_i[4:0];
                    end
                end
                IDX_IN_POL_HI: begin
                    rd = {27'h0000000, s_r.stored.in_pol_hi};
                    cfg_wr = wr;
                    if (wr && !servo_active && wb_sel_i[0]) begin
                        s_nxt.stored.in_pol_hi = wb_dat_i[4:0];
                    end
                end
                IDX_OUT_POL: begin
                    rd = {27'h0000000, s_r.stored.out_pol};
                    cfg_wr = wr;
                    if (wr && !servo_active && wb_sel_i[0]) begin
                        s_nxt.stored.out_pol = wb_dat_i[4:0];
                    end
                end
                IDX_STATUS: begin
                    rd = {29'h00000000, s_r.status};
                    if (wr && wb_sel_i[0]) begin
                        st_clr = wb_dat_i[ST_W-1:0];
                    end
                end
                IDX_MASK: begin
                    rd = {29'h00000000, s_r.mask};
                    if (wr && wb_sel_i[0]) begin
                        s_nxt.mask = wb_dat_i[ST_W-1:0];
                    end
                end
                IDX_IN_FUNC: begin
                    rd = {12'h000, s_r.in_func};
                end
                IDX_CONTACTS: begin
                    rd = {11'h000, s_r.out_c, 6'h00, input_contacts};
                end
                IDX_DIAG: begin
                    rd = {24'h000000, pending, s_r.alarm, 1'b0, s_r.dual};
                end
                // unmapped words answer with zero and ignore writes
                default: begin
                    rd = 32'h0000_0000;
                end
            endcase
        end

        // the write is still acknowledged so the master never hangs
        refused = cfg_wr & servo_active;

        s_nxt.dat = (req && !wb_we_i) ? rd : 32'h0000_0000;

        // new settings reach the routing only at boot or on a power-cycle
        // reload, and never while the servo is on
        s_nxt.boot = 1'b0;
        if (s_r.boot || (cfg_reload && !servo_active)) begin
            s_nxt.active = s_nxt.stored;
        end

        // events; a set in the same cycle as a clear wins
        st_set = '0;
        st_set[ST_DUAL] = dual_any & ~s_r.alarm;
        st_set[ST_REFUSED] = refused;
        // pending flags only its rising, so a long wait for reload raises it once
        st_set[ST_PENDING] = (s_nxt.stored != s_nxt.active) & ~pending;
        s_nxt.status = (s_r.status & ~st_clr) | st_set;
        s_nxt.irq = |(s_nxt.status & s_nxt.mask);

        s_nxt.alarm = dual_any;
        s_nxt.dual = rt_dual;
        s_nxt.in_func = rt_in_fn;
        s_nxt.out_c = rt_out_c;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r <= SFM_STATE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign in_func = sfm_in_fn_s'(s_r.in_func);
    assign output_contacts = s_r.out_c;
    assign output_dual_assign_alarm = s_r.alarm;
    assign irq = s_r.irq;
endmodule
`default_nettype wire

//--- rtl/sfm_pkg.sv
// package: constants, configuration layout and state of the servo function mapper
`default_nettype none
package sfm_pkg;
    localparam int NUM_IN = 10;
    localparam int NUM_OUT = 5;
    localparam int NUM_IN_FN = 20;
    localparam int NUM_OUT_FN = 9;
    localparam int DIGIT_W = 4;

    // allocation word and polarity reset values
    localparam logic [15:0] IN_ALLOC_1_RST = 16'h4321;
    localparam logic [15:0] IN_ALLOC_2_RST = 16'h8765;
    localparam logic [15:0] IN_ALLOC_3_RST = 16'h00A9;
    localparam logic [15:0] IN_ALLOC_4_RST = 16'h0000;
    localparam logic [15:0] IN_ALLOC_5_RST = 16'h0F00;
    localparam logic [15:0] OUT_ALLOC_1_RST = 16'h4321;
    localparam logic [15:0] OUT_ALLOC_2_RST = 16'h0005;
    localparam logic [15:0] OUT_ALLOC_3_RST = 16'h0000;
    localparam logic [4:0] IN_POL_LO_RST = 5'h1F;
    localparam logic [4:0] IN_POL_HI_RST = 5'h11;
    localparam logic [4:0] OUT_POL_RST = 5'h16;

    // word indexes; byte address is four times the index
    localparam logic [5:0] IDX_IN_ALLOC = 6'h00;
    localparam logic [5:0] IDX_OUT_ALLOC = 6'h05;
    localparam logic [5:0] IDX_IN_POL_LO = 6'h08;
    localparam logic [5:0] IDX_IN_POL_HI = 6'h09;
    localparam logic [5:0] IDX_OUT_POL = 6'h0A;
    localparam logic [5:0] IDX_STATUS = 6'h0B;
    localparam logic [5:0] IDX_MASK = 6'h0C;
    localparam logic [5:0] IDX_IN_FUNC = 6'h0D;
    localparam logic [5:0] IDX_CONTACTS = 6'h0E;
    localparam logic [5:0] IDX_DIAG = 6'h0F;

    // status and mask bit positions
    localparam int ST_DUAL = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_PENDING = 2;
    localparam int ST_W = 3;

    typedef struct packed {
        logic [4:0][15:0] in_alloc;
        logic [2:0][15:0] out_alloc;
        logic [4:0] in_pol_hi;
        logic [4:0] in_pol_lo;
        logic [4:0] out_pol;
    } sfm_cfg_s;

    localparam sfm_cfg_s SFM_CFG_RST = '{
        in_alloc: {IN_ALLOC_5_RST, IN_ALLOC_4_RST, IN_ALLOC_3_RST,
                   IN_ALLOC_2_RST, IN_ALLOC_1_RST},
        out_alloc: {OUT_ALLOC_3_RST, OUT_ALLOC_2_RST, OUT_ALLOC_1_RST},
        in_pol_hi: IN_POL_HI_RST,
        in_pol_lo: IN_POL_LO_RST,
        out_pol: OUT_POL_RST
    };

    // input functions, bit 0 is digit 1 of the first input allocation word
    typedef struct packed {
        logic absolute_reset_in;
        logic zero_clamp_in;
        logic absolute_data_request;
        logic mode_switch_in;
        logic torque_limit_in;
        logic pulse_clear_in;
        logic second_gain_select;
        logic proportional_switch_in;
        logic gear_ratio_sel_b;
        logic gear_ratio_sel_a;
        logic stop_in;
        logic emergency_stop_in;
        logic cw_limit_in;
        logic ccw_limit_in;
        logic direction_in;
        logic alarm_reset_in;
        logic speed_sel_3;
        logic speed_sel_2;
        logic speed_sel_1;
        logic servo_enable_in;
    } sfm_in_fn_s;

    // output functions, bit 0 is digit 1 of the first output allocation word
    typedef struct packed {
        logic warning_out;
        logic speed_reached_out;
        logic velocity_limiting_out;
        logic torque_limiting_out;
        logic in_position_out;
        logic brake_out;
        logic zero_speed_out;
        logic ready_out;
        logic alarm_out;
    } sfm_out_fn_s;

    typedef struct packed {
        sfm_cfg_s stored;
        sfm_cfg_s active;
        logic boot;
        logic ack;
        logic [31:0] dat;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic irq;
        logic alarm;
        logic [NUM_OUT-1:0] dual;
        logic [NUM_IN_FN-1:0] in_func;
        logic [NUM_OUT-1:0] out_c;
    } sfm_state_s;

    localparam sfm_state_s SFM_STATE_RST = '{
        stored: SFM_CFG_RST,
        active: SFM_CFG_RST,
        boot: 1'b1,
        default: '0
    };
endpackage
`default_nettype wire

//--- rtl/sfm_route.sv
// combinational contact-to-function routing with polarity and double-allocation detect
`default_nettype none
module sfm_route (
    input wire sfm_pkg::sfm_cfg_s cfg,
    input wire logic [sfm_pkg::NUM_IN-1:0] raw_in,
    input wire logic [sfm_pkg::NUM_OUT_FN-1:0] out_fn,
    output logic [sfm_pkg::NUM_IN_FN-1:0] in_fn,
    output logic [sfm_pkg::NUM_OUT-1:0] out_c,
    output logic [sfm_pkg::NUM_OUT-1:0] dual
);
    import sfm_pkg::*;

    logic [NUM_IN-1:0] in_pol;
    logic [NUM_IN-1:0] logical;
    logic [15:0] in_lut;
    logic [NUM_OUT_FN-1:0][15:0] out_dec;
    logic [NUM_OUT-1:0][NUM_OUT_FN-1:0] hit;

    assign in_pol = {cfg.in_pol_hi, cfg.in_pol_lo};
    // polarity 1 passes the level, 0 inverts it
    assign logical = raw_in ~^ in_pol;
    // digit 0 and digits above the contact count read as inactive
    assign in_lut = {5'h00, logical, 1'b0};

    genvar i, j, k;
    generate
        for (i = 0; i < NUM_IN_FN; i++) begin : g_in
            logic [DIGIT_W-1:0] dig;
            assign dig = cfg.in_alloc[i/4][(i%4)*DIGIT_W +: DIGIT_W];
            assign in_fn[i] = in_lut[dig];
        end
        for (j = 0; j < NUM_OUT_FN; j++) begin : g_dec
            logic [DIGIT_W-1:0] dig;
            assign dig = cfg.out_alloc[j/4][(j%4)*DIGIT_W +: DIGIT_W];
            assign out_dec[j] = 16'h0001 << dig;
        end
        for (k = 0; k < NUM_OUT; k++) begin : g_out
            for (j = 0; j < NUM_OUT_FN; j++) begin : g_hit
                assign hit[k][j] = out_dec[j][k+1];
            end
            // a contact no function claims stays in its idle level
            assign out_c[k] = (|(hit[k] & out_fn)) ~^ cfg.out_pol[k];
            // more than one bit set in the claim vector
            assign dual[k] = |(hit[k] & (hit[k] - NUM_OUT_FN'(1)));
        end
    endgenerate
endmodule
`default_nettype wire

//--- dv/sfm_mapper_sva.sv
// checker: bus handshake, routing latency and alarm causes of the function mapper
`default_nettype none
module sfm_mapper_sva (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic servo_active,
    input wire logic cfg_reload,
    input wire logic [sfm_pkg::NUM_IN-1:0] input_contacts,
    input wire sfm_pkg::sfm_out_fn_s out_func,
    input wire sfm_pkg::sfm_in_fn_s in_func,
    input wire logic [sfm_pkg::NUM_OUT-1:0] output_contacts,
    input wire logic output_dual_assign_alarm,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import sfm_pkg::*;
    ////////////////////////////////////////
    logic [1:0] rst_q;
    logic rl_q;
    sfm_out_fn_s of_q;
    logic [NUM_IN-1:0] ic_q;
    logic cfg_cause;
    logic oc_chg;
    logic ic_chg;
    // config only moves on a reload with servo off or around reset
    always_ff @(posedge clk) begin
        rst_q <= {rst_q[0], sys_rst};
        rl_q <= cfg_reload && !servo_active;
        of_q <= out_func;
        ic_q <= input_contacts;
    end
    assign cfg_cause = rl_q || (|rst_q);
    assign oc_chg = out_func != of_q;
    assign ic_chg = input_contacts != ic_q;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0)
        else $error("read data outside ack");
    chk_boot_quiet: assert property ($fell(sys_rst) |-> in_func == '0 && output_contacts == '0
        && !output_dual_assign_alarm)
        else $error("outputs not quiet after reset");
    chk_alarm_reload: assert property ($changed(output_dual_assign_alarm) |-> $past(cfg_cause))
        else $error("alarm moved without reload");
    chk_contact_cause: assert property ($changed(output_contacts) |->
        $past(cfg_cause) || $past(oc_chg))
        else $error("output contacts moved without cause");
    chk_input_cause: assert property ($changed(in_func) |->
        $past(cfg_cause) || $past(ic_chg))
        else $error("input functions moved without cause");
    cover property ($rose(output_dual_assign_alarm));
    cover property ($rose(irq));
    cover property (wb_ack_o && servo_active);
endmodule
bind sfm_mapper sfm_mapper_sva sfm_mapper_sva_inst (.clk(clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .servo_active(servo_active), .cfg_reload(cfg_reload), .input_contacts(input_contacts),
    .out_func(out_func), .in_func(in_func), .output_contacts(output_contacts),
    .output_dual_assign_alarm(output_dual_assign_alarm), .irq(irq));
`default_nettype wire

//--- dv/sfm_field.sv
// field side model: contact closures as the drive pins see them
`default_nettype none
module sfm_field (
    input wire logic clk,
    input wire logic [sfm_pkg::NUM_IN-1:0] closed,
    output logic [sfm_pkg::NUM_IN-1:0] input_contacts
);
    timeunit 1ns;
    timeprecision 1ps;
    import sfm_pkg::*;
    // a closed contact reads high; levels move only after an edge, like real wiring
    always_ff @(posedge clk) begin
        input_contacts <= closed;
    end
endmodule
`default_nettype wire

//--- dv/servo_io_function_mapper_bench.sv
// self-checking bench of the servo function mapper
`default_nettype none
module servo_io_function_mapper_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sfm_pkg::*;
    logic clk, sys_rst, cyc, stb, we, servo_active, cfg_reload, ack, alarm, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, dat_o;
    logic [NUM_IN-1:0] contacts, closed;
    logic [NUM_OUT-1:0] oc;
    sfm_out_fn_s out_func;
    sfm_in_fn_s in_func;
    int fails, n_checks;
    logic [7:0] ra [10] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28,
        8'h40};
    logic [31:0] rv [10] = '{32'h4321, 32'h0, 32'hF00, 32'h4321, 32'h5, 32'h0, 32'h1F,
        32'h11, 32'h16, 32'h0};
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    sfm_field sfm_field_inst (.clk(clk), .closed(closed), .input_contacts(contacts));
    sfm_mapper sfm_mapper_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .servo_active(servo_active), .cfg_reload(cfg_reload),
        .input_contacts(contacts), .out_func(out_func), .in_func(in_func),
        .output_contacts(oc), .output_dual_assign_alarm(alarm), .irq(irq));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (fails == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one classic cycle; request held until ack is sampled, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk);
        if (k == 20) begin
            fails++;
            end_of_test();
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        check(what, rdat, exp);
    endtask
    // field register plus one cycle of routing, sampled a cycle later
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask
    task automatic reload;
        cfg_reload <= 1'b1;
        @(posedge clk);
        cfg_reload <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    ////////////////////////////////////////
    initial begin
        {sys_rst, cyc, stb, we, servo_active, cfg_reload} = 6'h20;
        {adr, wdat, closed, out_func} = '0;
        sel = 4'hF;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        foreach (ra[i]) rd(ra[i], rv[i], "reset value");
        settle();
        check("idle contacts", 32'(oc), 32'h09);
        check("idle inputs", 32'(in_func), 32'h1C0);
        for (int k = 0; k < NUM_OUT_FN; k++) begin
            out_func <= sfm_out_fn_s'(9'h001 << k);
            settle();
            check("output route", 32'(oc), k < 5 ? 32'h09 ^ (32'h1 << k) : 32'h09);
        end
        out_func <= '0;
        for (int k = 0; k < NUM_IN; k++) begin
            closed <= 10'h001 << k;
            settle();
            check("input route", 32'(in_func), 32'h1C0 ^ (32'h1 << k));
        end
        closed <= '0;
        servo_active <= 1'b1;
        xfer(1'b1, 8'h18, 32'h15);
        rd(8'h18, 32'h5, "refused word");
        rd(8'h2C, 32'h2, "refusal status");
        check("masked irq", 32'(irq), 32'h0);
        xfer(1'b1, 8'h2C, 32'h7);
        servo_active <= 1'b0;
        xfer(1'b1, 8'h18, 32'h15);
        xfer(1'b1, 8'h30, 32'h1);
        rd(8'h18, 32'h15, "stored word");
        check("alarm before reload", 32'(alarm), 32'h0);
        reload();
        check("dual alarm", 32'(alarm), 32'h1);
        check("alarm irq", 32'(irq), 32'h1);
        rd(8'h2C, 32'h5, "alarm status");
        xfer(1'b1, 8'h2C, 32'h7);
        check("cleared irq", 32'(irq), 32'h0);
        xfer(1'b1, 8'h18, 32'h5);
        xfer(1'b1, 8'h28, 32'h1F);
        xfer(1'b1, 8'h20, 32'h0);
        reload();
        check("alarm gone", 32'(alarm), 32'h0);
        check("normal outputs", 32'(oc), 32'h0);
        check("inverted inputs", 32'(in_func), 32'h1DF);
        // low byte lane only: the upper byte of the word must stay as stored
        sel <= 4'h1;
        xfer(1'b1, 8'h0C, 32'hFFFF_FF01);
        sel <= 4'hF;
        rd(8'h0C, 32'h1, "byte lane write");
        reload();
        check("added input route", 32'(in_func), 32'h11DF);
        // second reset in mid-run restores every default
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rd(8'h0C, 32'h0, "word after reset");
        settle();
        check("contacts after reset", 32'(oc), 32'h09);
        check("inputs after reset", 32'(in_func), 32'h1C0);
        end_of_test();
    end
endmodule
`default_nettype wire
